// ===== shared/gfo_pkg.sv
// Package of constants and types for the pin and fault output logic.
package gfo_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_FA_MASK_LO = 8'h15;
  localparam logic [7:0] OFS_FA_MASK_HI = 8'h16;
  localparam logic [7:0] OFS_FB_MASK_LO = 8'h17;
  localparam logic [7:0] OFS_FB_MASK_HI = 8'h18;
  localparam logic [7:0] OFS_PIN_OUT = 8'h1A;
  localparam logic [7:0] OFS_PIN_IN = 8'h1B;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int NUM_PINS = 6;
  localparam int NUM_CH = 12;
  localparam int NUM_TRK = 4;
  localparam int HI_CH_LSB = 0;
  localparam int HI_CH_W = 4;
  localparam int POS_OV_EN = 4;
  localparam int POS_UV_EN = 5;
  localparam int POS_EW_EN = 6;
  localparam int POS_POL = 7;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [5:0] RST_PINS = 6'h00;

  // Pin mode codes; the configuration registers live outside this block.
  localparam logic [2:0] MODE_SPECIAL_IN = 3'h0;
  localparam logic [2:0] MODE_PP_IO = 3'h1;
  localparam logic [2:0] MODE_OD_IO = 3'h2;
  localparam logic [2:0] MODE_PP_FAULT = 3'h3;
  localparam logic [2:0] MODE_OD_FAULT = 3'h4;

  // Per-channel threshold violation flags.
  typedef struct packed {
    logic [NUM_CH-1:0] ov;
    logic [NUM_CH-1:0] uv;
    logic [NUM_CH-1:0] ew;
  } gfo_viol_s;

  // Register bus request.
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gfo_req_s;

  // Drive level and drive enable for six pins.
  typedef struct packed {
    logic [NUM_PINS-1:0] o;
    logic [NUM_PINS-1:0] oe;
  } gfo_pin_s;

endpackage

// ===== logic/gfo_top.sv
// Pin data and fault output logic of the supply manager.
`timescale 1ns/1ps
module gfo_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire gfo_pkg::gfo_req_s i_req,
  output logic [7:0] o_rdata,
  input wire logic [5:0] i_pin,
  output gfo_pkg::gfo_pin_s o_pin,
  input wire logic [17:0] i_pin_mode,
  input wire gfo_pkg::gfo_viol_s i_viol,
  input wire logic i_margin_en,
  input wire logic [3:0] i_pulldown_en,
  output logic [3:0] o_pulldown_on,
  input wire logic [3:0] i_track_ok,
  output logic [3:0] o_track_done,
  output logic o_any_fault,
  output logic o_fault_output_a,
  output logic o_fault_output_b
);

  // ****************************************
  // Helpers
  // ****************************************

  // Fault dependence: OR over selected channels of enabled violations.
  function automatic logic fault_hit(input logic [7:0] lo,
                                     input logic [7:0] hi,
                                     input gfo_pkg::gfo_viol_s v);
    logic [gfo_pkg::NUM_CH-1:0] sel;
    logic [gfo_pkg::NUM_CH-1:0] bad;
    sel = {hi[gfo_pkg::HI_CH_LSB +: gfo_pkg::HI_CH_W], lo};
    bad = (v.ov & {gfo_pkg::NUM_CH{hi[gfo_pkg::POS_OV_EN]}})
        | (v.uv & {gfo_pkg::NUM_CH{hi[gfo_pkg::POS_UV_EN]}})
        | (v.ew & {gfo_pkg::NUM_CH{hi[gfo_pkg::POS_EW_EN]}});
    return |(sel & bad);
  endfunction

  // Write strobe decode for one offset.
  function automatic logic wr_hit(input gfo_pkg::gfo_req_s r,
                                  input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] fa_lo_q;
  logic [7:0] fa_hi_q;
  logic [7:0] fb_lo_q;
  logic [7:0] fb_hi_q;
  logic [5:0] pin_out_q;
  logic [5:0] pin_in_q;
  logic fa_act_q;
  logic fb_act_q;
  logic any_act_q;
  logic [2:0] mode [gfo_pkg::NUM_PINS];

  // Fault a configuration, both mask and control byte.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fa_lo_q <= gfo_pkg::RST_REG;
      fa_hi_q <= gfo_pkg::RST_REG;
    end else begin
      if (wr_hit(i_req, gfo_pkg::OFS_FA_MASK_LO)) begin
        fa_lo_q <= i_req.wdata;
      end
      if (wr_hit(i_req, gfo_pkg::OFS_FA_MASK_HI)) begin
        fa_hi_q <= i_req.wdata;
      end
    end
  end

  // Fault b configuration.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fb_lo_q <= gfo_pkg::RST_REG;
      fb_hi_q <= gfo_pkg::RST_REG;
    end else begin
      if (wr_hit(i_req, gfo_pkg::OFS_FB_MASK_LO)) begin
        fb_lo_q <= i_req.wdata;
      end
      if (wr_hit(i_req, gfo_pkg::OFS_FB_MASK_HI)) begin
        fb_hi_q <= i_req.wdata;
      end
    end
  end

  // Output data starts at zero: it is never loaded from nonvolatile memory.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_out_q <= gfo_pkg::RST_PINS;
    end else if (wr_hit(i_req, gfo_pkg::OFS_PIN_OUT)) begin
      pin_out_q <= i_req.wdata[5:0];
    end
  end

  // Input state samples the pins every cycle; bus writes never reach it.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_in_q <= gfo_pkg::RST_PINS;
    end else begin
      pin_in_q <= i_pin;
    end
  end

  // Read data is registered, one cycle after the address; unmapped reads 0.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= gfo_pkg::RST_REG;
    end else begin
      unique case (i_req.addr)
        gfo_pkg::OFS_FA_MASK_LO: o_rdata <= fa_lo_q;
        gfo_pkg::OFS_FA_MASK_HI: o_rdata <= fa_hi_q;
        gfo_pkg::OFS_FB_MASK_LO: o_rdata <= fb_lo_q;
        gfo_pkg::OFS_FB_MASK_HI: o_rdata <= fb_hi_q;
        gfo_pkg::OFS_PIN_OUT: o_rdata <= {2'b00, pin_out_q};
        gfo_pkg::OFS_PIN_IN: o_rdata <= {2'b00, pin_in_q};
        default: o_rdata <= gfo_pkg::RST_REG;
      endcase
    end
  end

  // ****************************************
  // Fault outputs
  // ****************************************

  // Active state of each fault; held while margining so that planned
  // excursions neither raise nor clear a fault.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fa_act_q <= 1'b0;
      fb_act_q <= 1'b0;
      any_act_q <= 1'b0;
    end else if (!i_margin_en) begin
      fa_act_q <= fault_hit(fa_lo_q, fa_hi_q, i_viol);
      fb_act_q <= fault_hit(fb_lo_q, fb_hi_q, i_viol);
      any_act_q <= |{i_viol.ov, i_viol.uv, i_viol.ew};
    end
  end

  // Fault levels, polarity bit applied to a and b. Outputs lag the violation by two
  // clocks, trading latency for glitch-free flip-flop outputs. They hold
  // while margining too, so a polarity write cannot move a frozen output.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_any_fault <= 1'b1;
      o_fault_output_a <= 1'b1;
      o_fault_output_b <= 1'b1;
    end else if (!i_margin_en) begin
      o_any_fault <= ~any_act_q;
      o_fault_output_a <= fa_act_q ~^ fa_hi_q[gfo_pkg::POS_POL];
      o_fault_output_b <= fb_act_q ~^ fb_hi_q[gfo_pkg::POS_POL];
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < gfo_pkg::NUM_PINS; g++) begin : g_pin
      assign mode[g] = i_pin_mode[3*g +: 3];

      // Level each pin wants: fault level in the two fault modes, data bit otherwise.
      logic lvl;
      logic fault_mode;
      always_comb begin
        fault_mode = (mode[g] == gfo_pkg::MODE_PP_FAULT)
                   || (mode[g] == gfo_pkg::MODE_OD_FAULT);
        if (fault_mode) begin
          if (g == 4) begin
            lvl = o_fault_output_a;
          end else if (g == 5) begin
            lvl = o_fault_output_b;
          end else begin
            lvl = o_any_fault;
          end
        end else begin
          lvl = pin_out_q[g];
        end
      end

      // Open-drain only pulls low; push-pull drives both levels.
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          o_pin.o[g] <= 1'b0;
          o_pin.oe[g] <= 1'b0;
        end else begin
          unique case (mode[g])
            gfo_pkg::MODE_PP_IO, gfo_pkg::MODE_PP_FAULT: begin
              o_pin.o[g] <= lvl;
              o_pin.oe[g] <= 1'b1;
            end
            gfo_pkg::MODE_OD_IO, gfo_pkg::MODE_OD_FAULT: begin
              o_pin.o[g] <= 1'b0;
              o_pin.oe[g] <= ~lvl;
            end
            default: begin
              o_pin.o[g] <= 1'b0;
              o_pin.oe[g] <= 1'b0;
            end
          endcase
        end
      end
    end

    // Tracking sense pins: pulldown and ramp-reached flag per channel.
    for (g = 0; g < gfo_pkg::NUM_TRK; g++) begin : g_trk
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          o_pulldown_on[g] <= 1'b0;
          o_track_done[g] <= 1'b0;
        end else begin
          o_pulldown_on[g] <= i_pulldown_en[g]
            && (mode[g] == gfo_pkg::MODE_SPECIAL_IN);
          o_track_done[g] <= i_track_ok[g]
            && (mode[g] == gfo_pkg::MODE_SPECIAL_IN);
        end
      end
    end
  endgenerate

endmodule

// ===== sim/gfo_properties.sv
// Port-level checks for the pin and fault output block.
`timescale 1ns/1ps
module gfo_properties (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire gfo_pkg::gfo_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic [5:0] i_pin,
  input wire gfo_pkg::gfo_pin_s o_pin,
  input wire logic [17:0] i_pin_mode,
  input wire gfo_pkg::gfo_viol_s i_viol,
  input wire logic i_margin_en,
  input wire logic [3:0] i_pulldown_en,
  input wire logic [3:0] o_pulldown_on,
  input wire logic [3:0] i_track_ok,
  input wire logic [3:0] o_track_done,
  input wire logic o_any_fault,
  input wire logic o_fault_output_a,
  input wire logic o_fault_output_b
);
  // ****************************************
  // Properties
  // ****************************************
  logic [3:0] trk_mode;
  // Only pins left in mode zero may act as tracking sense inputs.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      trk_mode[k] = i_pin_mode[3*k +: 3] == 3'h0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_cfg_rb;
    (i_req.wr && i_req.addr inside {8'h15, 8'h16, 8'h17, 8'h18}) ##1
    (!i_req.wr && $stable(i_req.addr)) |=> o_rdata == $past(i_req.wdata, 2);
  endproperty
  a_cfg_rb: assert property (p_cfg_rb)
    else $error("config readback wrong");
  property p_out_rb;
    (i_req.wr && i_req.addr == 8'h1A) ##1 (!i_req.wr && i_req.addr == 8'h1A)
    |=> o_rdata == {2'b00, $past(i_req.wdata[5:0], 2)};
  endproperty
  a_out_rb: assert property (p_out_rb)
    else $error("output data readback wrong");
  property p_in_rb;
    (i_req.addr == 8'h1B && !$past(i_sys_rst))
    |=> o_rdata == {2'b00, $past(i_pin, 2)};
  endproperty
  a_in_rb: assert property (p_in_rb)
    else $error("input state readback wrong");
  property p_pin_drv;
    (i_req.wr && i_req.addr == 8'h1A) ##1
    (i_pin_mode[2:0] == 3'h1 && $stable(i_pin_mode))
    |=> o_pin.o[0] == $past(i_req.wdata[0], 2) && o_pin.oe[0];
  endproperty
  a_pin_drv: assert property (p_pin_drv)
    else $error("pin level wrong");
  property p_trk;
    !$past(i_sys_rst) |-> o_track_done == $past(i_track_ok & trk_mode)
    && o_pulldown_on == $past(i_pulldown_en & trk_mode);
  endproperty
  a_trk: assert property (p_trk)
    else $error("tracking pin outputs wrong");
  property p_any;
    !i_margin_en [*3] |-> o_any_fault == !$past(|i_viol, 2);
  endproperty
  a_any: assert property (p_any)
    else $error("combined fault wrong");
  property p_freeze;
    i_margin_en [*3] |-> $stable(o_fault_output_a)
    && $stable(o_fault_output_b) && $stable(o_any_fault);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("fault outputs moved while frozen");
  property p_rst;
    $past(i_sys_rst) |-> o_rdata == 8'h00 && o_pin == '0 && o_any_fault
    && o_fault_output_a && o_fault_output_b;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
endmodule
bind gfo_top gfo_properties u_props (.*);

// ===== sim/gfo_far_side.sv
// Board-side model that resolves the six pin wires.
`timescale 1ns/1ps
module gfo_far_side (
  input wire gfo_pkg::gfo_pin_s i_drv,
  input wire logic [5:0] i_ext,
  output logic [5:0] o_level
);
  // ****************************************
  // Wire resolution
  // ****************************************
  // A released pin shows the board level, which the bench varies so that
  // a stale driven value can never pass for a match.
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      o_level[k] = i_drv.oe[k] ? i_drv.o[k] : i_ext[k];
    end
  end
endmodule

// ===== sim/tb.sv
// Self-checking bench for the pin and fault output block.
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_margin_en = 1'b0;
  gfo_pkg::gfo_req_s i_req = '0;
  gfo_pkg::gfo_viol_s i_viol = '0;
  gfo_pkg::gfo_pin_s o_pin;
  logic [17:0] i_pin_mode = '0;
  logic [3:0] i_pulldown_en = '0, i_track_ok = '0, o_pulldown_on, o_track_done;
  logic [7:0] o_rdata;
  logic [5:0] pin_lvl, ext = '0;
  logic o_any_fault, o_fault_output_a, o_fault_output_b;
  logic [31:0] seed = 32'h0000_04F1;
  logic [7:0] cfg [4];
  logic [7:0] ofs [8] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h1A, 8'h1B, 8'h20,
                          8'h1C};
  int fails = 0, n_checks = 0, cyc = 0;
  // ****************************************
  // Instances, clock and helpers
  // ****************************************
  gfo_top u_dut (.i_pin(pin_lvl), .*);
  gfo_far_side u_far (.i_drv(o_pin), .i_ext(ext), .o_level(pin_lvl));
  always #20 i_clk = ~i_clk;
  // The whole run needs well under a thousand cycles.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Polarity bit equal to the OR of selected violations gives the level.
  function automatic logic flt(int n);
    logic [11:0] s;
    s = (i_viol.ov & {12{cfg[n+1][4]}}) | (i_viol.uv & {12{cfg[n+1][5]}})
      | (i_viol.ew & {12{cfg[n+1][6]}});
    return cfg[n+1][7] ~^ |({cfg[n+1][3:0], cfg[n]} & s);
  endfunction
  function automatic logic [7:0] rd_exp(logic [7:0] a, logic [7:0] d);
    case (a)
      8'h15, 8'h16, 8'h17, 8'h18: return d;
      8'h1A: return {2'b00, d[5:0]};
      8'h1B: return {2'b00, ext};
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write holds for exactly one edge; read data is looked at after it.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_req <= '{wr: w, addr: a, wdata: d};
    @(posedge i_clk);
    i_req.wr <= 1'b0;
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [63:0] v;
    logic [2:0] e;
    logic [5:0] o, oe;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    ext <= 6'h2D;
    // Registers, the read-only place and unmapped places, pins in mode zero.
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      if (i % 8 < 4) cfg[i % 8] = d[7:0];
      @(posedge i_clk);
      i_pulldown_en <= d[11:8];
      i_track_ok <= d[15:12];
      acc(1'b1, ofs[i % 8], d[7:0]);
      acc(1'b0, ofs[i % 8], 8'h00);
      chk({8'h00, o_rdata}, {8'h00, rd_exp(ofs[i % 8], d[7:0])});
      chk({8'h00, o_pulldown_on, o_track_done}, {8'h00, d[11:8], d[15:12]});
    end
    // Faults on every pin, a frozen stretch, then a fresh configuration.
    for (int i = 0; i < 48; i++) begin
      v = {rnd(), rnd()} & {rnd(), rnd()} & {rnd(), rnd()};
      @(posedge i_clk);
      i_pin_mode <= 18'h1_B6DB;
      i_viol <= v[35:0];
      i_margin_en <= (i % 16 > 12);
      repeat (3) @(posedge i_clk);
      #1;
      if (!i_margin_en) e = {~|i_viol, flt(0), flt(2)};
      chk({1'b0, o_any_fault, o_fault_output_a, o_fault_output_b, o_pin.o,
           o_pin.oe}, {1'b0, e, e[0], e[1], {4{e[2]}}, 6'h3F});
      for (int r = 0; r < 4 && i % 16 == 15; r++) begin
        d = rnd();
        cfg[r] = d[7:0];
        acc(1'b1, ofs[r], d[7:0]);
      end
    end
    // Logic outputs, push-pull and open-drain in turn, read back as inputs.
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      @(posedge i_clk);
      i_margin_en <= 1'b0;
      i_pin_mode <= i[0] ? 18'h1_2492 : 18'h0_9249;
      ext <= d[13:8];
      i_pulldown_en <= d[19:16];
      i_track_ok <= d[23:20];
      acc(1'b1, 8'h1A, d[7:0]);
      repeat (2) @(posedge i_clk);
      #1;
      o = i[0] ? 6'h00 : d[5:0];
      oe = i[0] ? ~d[5:0] : 6'h3F;
      chk({4'h0, o_pin.o, o_pin.oe}, {4'h0, o, oe});
      chk({8'h00, o_pulldown_on, o_track_done}, 16'h0000);
      acc(1'b0, 8'h1B, 8'h00);
      chk({8'h00, o_rdata}, {10'h000, (o & oe) | (ext & ~oe)});
    end
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    acc(1'b0, 8'h1A, 8'h00);
    chk({8'h00, o_rdata}, 16'h0000);
    results();
  end
endmodule
